// ==== rtl/timer_pwm.sv ====
// Eight-bit timer with period and PWM output behind an APB slave
// Behaviour
// (RULE1) Clock codes: 0 off, 1 system, 2 fast, 3 xtal, 4 slow, 5 comparator.
// (RULE2) Codes 8..13 count rise/fall edges of pins A0, B0, A4; rest reserved.
// (RULE3) Fast oscillator clock keeps counting while emulator is halted.
// (RULE4) Output select routes waveform to none, A4, A5 or B7.
// (RULE5) Control bit 1 selects period mode (0) or PWM mode (1).
// (RULE6) Control bit 0 set inverts output polarity.
// (RULE7) Period mode gives 50% duty, period two times bound plus one ticks.
// (RULE8) Prescaler divides by 1, 4, 16 or 64.
// (RULE9) Scaler divides prescaled clock by value plus one.
// (RULE10) 8-bit PWM: period 256 ticks, high for bound plus one ticks.
// (RULE11) 6-bit PWM: period 64 ticks, high for bound plus one ticks.
// (RULE12) Divider bit 7 clear selects 8-bit PWM, set selects 6 or 7 bit.
// (RULE13) In period mode counter clears when it reaches the bound.
// (RULE14) Source passes prescaler then scaler; reserved codes stop counting.
`timescale 1ns/1ns
`include "timer_pwm_params.svh"
module timer_pwm
   import timer_pwm_pkg::*;
#(
   parameter bit FAST_DOUBLE = 1'b0,  // Fast oscillator at twice its rate
   parameter bit PWM_SEVEN   = 1'b0   // Reduced resolution is 7 bit, not 6
)
(
   input  wire logic        pclk,        // APB clock, 100 MHz
   input  wire logic        presetn,     // Async reset, active low
   input  wire logic        clk_en,      // Freezes all state when low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [11:0] paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error
   input  wire logic        emu_halt,    // Emulator halted
   input  wire logic        fast_tick,   // Fast oscillator tick
   input  wire logic        fast2_tick,  // Doubled fast oscillator tick
   input  wire logic        xtal_tick,   // Crystal tick
   input  wire logic        slow_tick,   // Slow oscillator tick
   input  wire logic        cmp_tick,    // Comparator output tick
   input  wire logic        port_a_bit0, // Pin input
   input  wire logic        port_b_bit0, // Pin input
   input  wire logic        port_a_bit4_in, // Pin input
   output logic             port_a_bit4, // Waveform to pin
   output logic             port_a_bit5, // Waveform to pin
   output logic             port_b_bit7, // Waveform to pin
   output logic             port_a_bit4_oe, // Drive enable
   output logic             port_a_bit5_oe, // Drive enable
   output logic             port_b_bit7_oe  // Drive enable
);
   logic [7:0]    timer_control_q;
   logic [7:0]    timer_divider_setting_q;
   logic [7:0]    timer_bound_value_q;
   logic [7:0]    timer_count_value_q;
   logic          wave_q;
   logic          tick;
   logic          tick_run;
   logic          sys_run;
   logic          setup;
   logic          wr_acc;
   logic [11:0]   widx;
   logic          hit;
   logic [7:0]    rd_byte;
   logic [7:0]    last;
   logic          pwm_mode;
   logic          out_lvl;
   logic [1:0]    osel;
   logic [3:0]    csel;
   apb_phase_type phase_q;

   assign csel     = timer_control_q[`CTL_CSEL_LSB +: 4];
   assign osel     = timer_control_q[`CTL_OSEL_LSB +: 2];
   assign pwm_mode = timer_control_q[`CTL_MODE_BIT];            // [RULE5]

   // ==========================================================
   // APB slave: one wait-free access, answer in the access cycle
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready;
   // One register per aligned word; the two low address bits are ignored
   assign widx   = {2'b00, paddr[11:2]};
   assign hit    = (widx == `OFS_CONTROL) || (widx == `OFS_COUNT) ||
                   (widx == `OFS_DIVIDER) || (widx == `OFS_BOUND);

   always_comb
   begin
      unique case (widx)
         `OFS_CONTROL: rd_byte = timer_control_q;
         `OFS_COUNT:   rd_byte = timer_count_value_q;
         default:      rd_byte = `RST_BYTE;  // Divider and bound: write-only
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_q <= bus_idle_type_s;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         unique case (phase_q)
            bus_idle_type_s:
            begin
               pready  <= setup;
               pslverr <= setup && !hit;
               prdata  <= setup && !pwrite ? {24'h00_0000, rd_byte}
                                           : 32'h0000_0000;
               if (setup)
                  phase_q <= bus_access_s;
            end
            bus_access_s:
            begin
               pready  <= 1'b0;
               pslverr <= 1'b0;
               phase_q <= bus_idle_type_s;
            end
         endcase
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_control_q         <= `RST_BYTE;
         timer_divider_setting_q <= `RST_BYTE;
         timer_bound_value_q     <= `RST_BYTE;
      end
      else if (clk_en && wr_acc)
      begin
         if (widx == `OFS_CONTROL)
            timer_control_q <= pwdata[7:0];
         if (widx == `OFS_DIVIDER)
            timer_divider_setting_q <= pwdata[7:0];
         if (widx == `OFS_BOUND)
            timer_bound_value_q <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Divided clock
   // System clock stops on halt; fast oscillator does not
   assign sys_run = !emu_halt;

   timer_tick_gen u_tick
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_en     (clk_en && tick_run),
      .clk_sel    (csel),
      .pre_sel    (timer_divider_setting_q[`DIV_PRE_LSB +: 2]),
      .scaler     (timer_divider_setting_q[`DIV_SCL_LSB +: 5]),
      .fast_dbl   (FAST_DOUBLE),
      .sys_tick   (sys_run),
      .fast_tick  (fast_tick),
      .fast2_tick (fast2_tick),
      .xtal_tick  (xtal_tick),
      .slow_tick  (slow_tick),
      .cmp_tick   (cmp_tick),
      .pin_a0     (port_a_bit0),
      .pin_b0     (port_b_bit0),
      .pin_a4     (port_a_bit4_in),
      .tick       (tick)
   );

   // Halt freezes every source except the fast oscillator
   assign tick_run = !emu_halt || (csel == `CSEL_FAST);         // [RULE3]

   // ==========================================================
   // Counter and waveform
   always_comb
   begin
      if (timer_divider_setting_q[`DIV_RES_BIT])                // [RULE12]
         last = PWM_SEVEN ? `PWM7_LAST : `PWM6_LAST;            // [RULE11]
      else
         last = `PWM8_LAST;                                     // [RULE10]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_count_value_q <= `RST_BYTE;
      else if (clk_en)
      begin
         if (wr_acc && widx == `OFS_COUNT)
            timer_count_value_q <= pwdata[7:0];
         else if (tick && tick_run)
         begin
            if (pwm_mode ? (timer_count_value_q >= last)        // [RULE10]
                         : (timer_count_value_q >= timer_bound_value_q))
               timer_count_value_q <= `RST_BYTE;                // [RULE13]
            else
               timer_count_value_q <= timer_count_value_q + 8'h01;
         end
      end
   end

   // Period mode toggles at every wrap, giving 50% duty
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wave_q <= 1'b0;
      else if (clk_en && tick && tick_run)
      begin
         if (pwm_mode)
            wave_q <= (timer_count_value_q >= last) ? 1'b1      // [RULE11]
                    : (timer_count_value_q < timer_bound_value_q); // [RULE10]
         else if (timer_count_value_q >= timer_bound_value_q)
            wave_q <= !wave_q;                                  // [RULE7]
      end
   end

   assign out_lvl = wave_q ^ timer_control_q[`CTL_INV_BIT];     // [RULE6]

   // ==========================================================
   // Pin routing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_a_bit4    <= 1'b0;
         port_a_bit5    <= 1'b0;
         port_b_bit7    <= 1'b0;
         port_a_bit4_oe <= 1'b0;
         port_a_bit5_oe <= 1'b0;
         port_b_bit7_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         port_a_bit4_oe <= (osel == `OSEL_A4);                  // [RULE4]
         port_a_bit5_oe <= (osel == `OSEL_A5);                  // [RULE4]
         port_b_bit7_oe <= (osel == `OSEL_B7);                  // [RULE4]
         port_a_bit4    <= (osel == `OSEL_A4) && out_lvl;
         port_a_bit5    <= (osel == `OSEL_A5) && out_lvl;
         port_b_bit7    <= (osel == `OSEL_B7) && out_lvl;
      end
   end

   // ==========================================================
   // Checks
   sequence wrap_s;
      tick && tick_run && !pwm_mode &&
      timer_count_value_q >= timer_bound_value_q;
   endsequence

   counter_wrap_a : assert property (@(posedge pclk) disable iff (!presetn)
      ((clk_en && !wr_acc) and wrap_s) |=> timer_count_value_q == 8'h00)
      else $error("counter did not clear at bound"); // [RULE13]

   period_toggle_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en and wrap_s) |=> wave_q != $past(wave_q))
      else $error("period wave did not toggle"); // [RULE7]

   pwm_wrap_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && tick_run && pwm_mode && !wr_acc &&
       timer_count_value_q == `PWM8_LAST &&
       !timer_divider_setting_q[`DIV_RES_BIT])
      |=> timer_count_value_q == 8'h00)
      else $error("8-bit pwm did not wrap at 255"); // [RULE10]

   pwm6_wrap_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && tick_run && pwm_mode && !wr_acc && !PWM_SEVEN &&
       timer_divider_setting_q[`DIV_RES_BIT] &&
       timer_count_value_q == `PWM6_LAST)
      |=> timer_count_value_q == 8'h00)
      else $error("6-bit pwm did not wrap at 63"); // [RULE11]

   pin_route_a : assert property (@(posedge pclk) disable iff (!presetn)
      clk_en |=> $onehot0({port_a_bit4_oe, port_a_bit5_oe, port_b_bit7_oe}))
      else $error("waveform driven on two pins"); // [RULE4]

   invert_out_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && osel == `OSEL_A5) |=> port_a_bit5 ==
         ($past(wave_q) ^ $past(timer_control_q[`CTL_INV_BIT])))
      else $error("output polarity wrong"); // [RULE6]

   halt_fast_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && emu_halt && csel == `CSEL_FAST && tick && !wr_acc)
      |=> ($changed(timer_count_value_q) || $changed(wave_q)))
      else $error("fast clock stopped by halt"); // [RULE3]

   stop_reserved_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && csel == 4'h7 && !wr_acc) |=> $stable(timer_count_value_q))
      else $error("reserved clock code advanced counter"); // [RULE14]
endmodule : timer_pwm

// ==== rtl/timer_tick_gen.sv ====
// Clock source selection, edge detect, prescaler and scaler
`timescale 1ns/1ns
`include "timer_pwm_params.svh"
module timer_tick_gen
   import timer_pwm_pkg::*;
(
   input  wire logic       pclk,       // System clock
   input  wire logic       presetn,    // Async reset, active low
   input  wire logic       clk_en,     // Freeze when low
   input  wire logic [3:0] clk_sel,    // Clock select code
   input  wire logic [1:0] pre_sel,    // Prescaler code
   input  wire logic [4:0] scaler,     // Scaler value
   input  wire logic       fast_dbl,   // Fast oscillator doubled
   input  wire logic       sys_tick,   // System clock enable
   input  wire logic       fast_tick,  // Fast oscillator tick
   input  wire logic       fast2_tick, // Doubled fast oscillator tick
   input  wire logic       xtal_tick,  // Crystal tick
   input  wire logic       slow_tick,  // Slow oscillator tick
   input  wire logic       cmp_tick,   // Comparator output tick
   input  wire logic       pin_a0,     // Pin level
   input  wire logic       pin_b0,     // Pin level
   input  wire logic       pin_a4,     // Pin level
   output logic            tick        // One divided clock
);
   logic [2:0] pin_q;
   logic [5:0] pre_q;
   logic [4:0] scl_q;
   logic       src;
   logic [5:0] pre_max;
   logic [2:0] rise;
   logic [2:0] fall;

   // ==========================================================
   // Pin edge detection
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_edge
         logic pin_now;
         assign pin_now = (g == 0) ? pin_a0 : (g == 1) ? pin_b0 : pin_a4;
         assign rise[g] = pin_now & ~pin_q[g];
         assign fall[g] = ~pin_now & pin_q[g];
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               pin_q[g] <= 1'b0;
            else if (clk_en)
               pin_q[g] <= pin_now;
         end
      end
   endgenerate

   // ==========================================================
   // Source selection
   always_comb
   begin
      unique case (clk_sel)
         `CSEL_SYS:     src = sys_tick;                         // [RULE1]
         `CSEL_FAST:    src = fast_dbl ? fast2_tick : fast_tick; // [RULE1]
         `CSEL_XTAL:    src = xtal_tick;                        // [RULE1]
         `CSEL_SLOW:    src = slow_tick;                        // [RULE1]
         `CSEL_CMP:     src = cmp_tick;                         // [RULE1]
         `CSEL_A0_RISE: src = rise[0];                          // [RULE2]
         `CSEL_A0_FALL: src = fall[0];                          // [RULE2]
         `CSEL_B0_RISE: src = rise[1];                          // [RULE2]
         `CSEL_B0_FALL: src = fall[1];                          // [RULE2]
         `CSEL_A4_RISE: src = rise[2];                          // [RULE2]
         `CSEL_A4_FALL: src = fall[2];                          // [RULE2]
         default:       src = 1'b0;                             // [RULE14]
      endcase
   end

   always_comb
   begin
      unique case (pre_sel)
         2'b00:   pre_max = 6'h00;                              // [RULE8]
         2'b01:   pre_max = `PRE_DIV4_MAX;                      // [RULE8]
         2'b10:   pre_max = `PRE_DIV16_MAX;                     // [RULE8]
         default: pre_max = `PRE_DIV64_MAX;                     // [RULE8]
      endcase
   end

   // ==========================================================
   // Prescaler then scaler; tick is one pclk wide per divided clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_q <= 6'h00;
         scl_q <= 5'h00;
         tick  <= 1'b0;
      end
      else if (clk_en)
      begin
         tick <= 1'b0;
         if (src)
         begin
            if (pre_q >= pre_max)                               // [RULE14]
            begin
               pre_q <= 6'h00;
               if (scl_q >= scaler)                             // [RULE9]
               begin
                  scl_q <= 5'h00;
                  tick  <= 1'b1;
               end
               else
                  scl_q <= scl_q + 5'h01;
            end
            else
               pre_q <= pre_q + 6'h01;
         end
      end
   end

   no_tick_off_a : assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && clk_sel == `CSEL_OFF) |=> !tick)              // [RULE14]
      else $error("tick while timer clock disabled");
endmodule : timer_tick_gen

// ==== shared/timer_pwm_params.svh ====
// Register offsets, field positions, reset values and codes for the PWM timer
`ifndef TIMER_PWM_PARAMS_SVH
`define TIMER_PWM_PARAMS_SVH
// Register word indices; the byte address is four times the index
`define OFS_CONTROL   12'h0032
`define OFS_COUNT     12'h0033
`define OFS_DIVIDER   12'h0034
`define OFS_BOUND     12'h0035
`define RST_BYTE      8'h00
`define CTL_INV_BIT   0
`define CTL_MODE_BIT  1
`define CTL_OSEL_LSB  2
`define CTL_CSEL_LSB  4
`define DIV_SCL_LSB   0
`define DIV_PRE_LSB   5
`define DIV_RES_BIT   7
`define CSEL_OFF      4'h0
`define CSEL_SYS      4'h1
`define CSEL_FAST     4'h2
`define CSEL_XTAL     4'h3
`define CSEL_SLOW     4'h4
`define CSEL_CMP      4'h5
`define CSEL_A0_RISE  4'h8
`define CSEL_A0_FALL  4'h9
`define CSEL_B0_RISE  4'hA
`define CSEL_B0_FALL  4'hB
`define CSEL_A4_RISE  4'hC
`define CSEL_A4_FALL  4'hD
`define OSEL_NONE     2'h0
`define OSEL_A4       2'h1
`define OSEL_A5       2'h2
`define OSEL_B7       2'h3
`define PRE_DIV4_MAX  6'h03
`define PRE_DIV16_MAX 6'h0F
`define PRE_DIV64_MAX 6'h3F
`define PWM8_LAST     8'hFF
`define PWM6_LAST     8'h3F
`define PWM7_LAST     8'h7F
`endif

// ==== shared/timer_pwm_pkg.sv ====
// Types shared by the PWM timer design
package timer_pwm_pkg;
   typedef enum logic [1:0] {
      bus_idle_type_s = 2'b00,
      bus_access_s    = 2'b01
   } apb_phase_type;
endpackage : timer_pwm_pkg

// ==== tb/pin_partner.sv ====
// Far-side model: source clock ticks and pin levels for the timer
`timescale 1ns/1ns
module pin_partner
#(
   parameter int FAST_P = 3,   // Fast oscillator tick spacing
   parameter int XTAL_P = 5,   // Crystal tick spacing
   parameter int SLOW_P = 7,   // Slow oscillator tick spacing
   parameter int CMP_P  = 4,   // Comparator tick spacing
   parameter int A0_H   = 6,   // Half period of pin A0
   parameter int B0_H   = 8,   // Half period of pin B0
   parameter int A4_H   = 10   // Half period of pin A4
)
(
   input  wire logic pclk,        // System clock
   input  wire logic presetn,     // Async reset, active low
   output logic      fast_tick,   // Fast oscillator tick
   output logic      fast2_tick,  // Doubled fast oscillator tick
   output logic      xtal_tick,   // Crystal tick
   output logic      slow_tick,   // Slow oscillator tick
   output logic      cmp_tick,    // Comparator tick
   output logic      port_a_bit0, // Pin level
   output logic      port_b_bit0, // Pin level
   output logic      port_a_bit4  // Pin level
);
   int n_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         n_q <= 0;
      else
         n_q <= n_q + 1;
   // Fixed spacing lets the bench predict every divided period
   assign fast_tick   = (n_q % FAST_P) == 0;
   assign fast2_tick  = (n_q % 2) == 0;
   assign xtal_tick   = (n_q % XTAL_P) == 0;
   assign slow_tick   = (n_q % SLOW_P) == 0;
   assign cmp_tick    = (n_q % CMP_P) == 0;
   assign port_a_bit0 = (n_q / A0_H) % 2;
   assign port_b_bit0 = (n_q / B0_H) % 2;
   assign port_a_bit4 = (n_q / A4_H) % 2;
endmodule : pin_partner

// ==== tb/testbench.sv ====
// Bench for the PWM timer: APB driver, reference model and scenarios
`timescale 1ns/1ns
`include "timer_pwm_params.svh"
module testbench;
   import timer_pwm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, emu_halt, en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r1;
   logic        pready, pslverr, er;
   logic        ft, f2t, xt, st, ct, a0, b0, a4i;
   logic        a4, a5, b7, a4oe, a5oe, b7oe;
   logic [1:0]  sel;
   int          n_fail, n_checks, hi, lo, k, p, s, i;
   int          codes[11] = '{1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13};
   int          per[11]   = '{1, 3, 5, 7, 4, 12, 12, 16, 16, 20, 20};
   int          stop[5]   = '{0, 6, 7, 14, 15};

   timer_pwm dut (.pclk(pclk), .presetn(presetn), .clk_en(en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .emu_halt(emu_halt), .fast_tick(ft),
      .fast2_tick(f2t), .xtal_tick(xt), .slow_tick(st), .cmp_tick(ct),
      .port_a_bit0(a0), .port_b_bit0(b0), .port_a_bit4_in(a4i),
      .port_a_bit4(a4), .port_a_bit5(a5), .port_b_bit7(b7),
      .port_a_bit4_oe(a4oe), .port_a_bit5_oe(a5oe),
      .port_b_bit7_oe(b7oe));
   pin_partner far (.pclk(pclk), .presetn(presetn), .fast_tick(ft),
      .fast2_tick(f2t), .xtal_tick(xt), .slow_tick(st), .cmp_tick(ct),
      .port_a_bit0(a0), .port_b_bit0(b0), .port_a_bit4(a4i));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   // ==========================================================
   // APB master: hold the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int j;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a << 2;  // Index to byte address of its word
      pwdata  <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (j = 0; j < 50; j++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (j == 50)
      begin
         n_fail++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cfg(input logic [3:0] c, input logic [1:0] o,
                      input logic m, v, r, input logic [1:0] pr,
                      input logic [4:0] sc, input logic [7:0] kb);
      apb(1'b1, `OFS_BOUND, kb);
      apb(1'b1, `OFS_DIVIDER, {r, pr, sc});
      apb(1'b1, `OFS_CONTROL, {c, o, m, v});
      sel = o;
   endtask : cfg

   function automatic logic pin();
      case (sel)
         2'd1: return a4;
         2'd2: return a5;
         default: return b7;
      endcase
   endfunction : pin

   // ==========================================================
   // Reference model: pclk cycles per divided clock
   function automatic int unit(input int pr, sc, src);
      return (1 << (2 * pr)) * (sc + 1) * src;
   endfunction : unit

   // Second full cycle is measured; the first may be cut by reconfig
   task automatic run_chk(input int eh, el);
      int j;
      repeat (2)
      begin
         hi = 0;
         lo = 0;
         for (j = 0; j < 20000 && pin() !== 1'b0; j++) @(posedge pclk);
         for (; j < 20000 && pin() !== 1'b1; j++) @(posedge pclk);
         for (; j < 20000 && pin() === 1'b1; j++)
         begin
            @(posedge pclk);
            hi++;
         end
         for (; j < 20000 && pin() === 1'b0; j++)
         begin
            @(posedge pclk);
            lo++;
         end
         if (j >= 20000)
         begin
            n_fail++;
            final_report();
         end
      end
      check("high time", hi, eh);
      check("low time", lo, el);
   endtask : run_chk

   task automatic frozen(input string nm);
      apb(1'b0, `OFS_COUNT, 8'h00);
      r1 = rd;
      repeat (20) @(posedge pclk);
      apb(1'b0, `OFS_COUNT, 8'h00);
      check(nm, rd, r1);
   endtask : frozen

   // ==========================================================
   initial
   begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0000_0000;
      emu_halt = 1'b0;
      en       = 1'b1;
      sel      = 2'd1;
      k        = $urandom(32'hd750eed3);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CONTROL, 8'h00);
      check("control reset", rd, 32'h0000_0000);
      apb(1'b0, `OFS_COUNT, 8'h00);
      check("counter reset", rd, 32'h0000_0000);
      apb(1'b0, 12'h040, 8'h00);
      check("unmapped error", er, 1'b1);
      apb(1'b1, `OFS_COUNT, 8'h5A);
      apb(1'b0, `OFS_COUNT, 8'h00);
      check("counter rw", rd, 32'h0000_005A);
      apb(1'b1, `OFS_CONTROL, 8'h0B);
      apb(1'b0, `OFS_CONTROL, 8'h00);
      check("control rw", rd, 32'h0000_000B);
      repeat (4)
      begin
         k = $urandom_range(7);
         p = $urandom_range(1);
         s = $urandom_range(3);
         cfg(4'h1, 2'd1, 0, 0, 0, 2'(p), 5'(s), 8'(k));
         run_chk((k + 1) * unit(p, s, 1), (k + 1) * unit(p, s, 1));
      end
      cfg(4'h1, 2'd2, 0, 0, 0, 2'd3, 5'd0, 8'd0);
      run_chk(64, 64);
      cfg(4'h1, 2'd3, 0, 0, 0, 2'd0, 5'd31, 8'd0);
      run_chk(32, 32);
      for (i = 1; i < 4; i++)
      begin
         cfg(4'h1, 2'(i), 0, 0, 0, 2'd0, 5'd0, 8'd1);
         run_chk(2, 2);
         check("pin enables", {b7oe, a5oe, a4oe}, 1 << (i - 1));
      end
      cfg(4'h1, 2'd0, 0, 0, 0, 2'd0, 5'd0, 8'd1);
      repeat (20) @(posedge pclk);
      check("no pin", {a4, a5, b7, a4oe, a5oe, b7oe}, 0);
      for (i = 0; i < 11; i++)
      begin
         cfg(4'(codes[i]), 2'd1, 0, 0, 0, 2'd0, 5'd0, 8'd1);
         run_chk(2 * per[i], 2 * per[i]);
      end
      k = $urandom_range(200);
      cfg(4'h1, 2'd1, 1, 0, 0, 2'd1, 5'd0, 8'(k));
      run_chk((k + 1) * 4, (255 - k) * 4);
      k = $urandom_range(62);
      cfg(4'h1, 2'd3, 1, 0, 1, 2'd0, 5'd1, 8'(k));
      run_chk((k + 1) * 2, (63 - k) * 2);
      cfg(4'h1, 2'd2, 1, 1, 0, 2'd0, 5'd0, 8'd9);
      run_chk(246, 10);
      cfg(4'h1, 2'd0, 0, 0, 0, 2'd0, 5'd0, 8'd9);
      repeat (12)
      begin
         apb(1'b0, `OFS_COUNT, 8'h00);
         check("count within bound", rd <= 9, 1'b1);
      end
      for (i = 0; i < 5; i++)
      begin
         apb(1'b1, `OFS_CONTROL, {4'(stop[i]), 4'h0});
         frozen("stopped count");
      end
      // Same span with enable high, then low: low must lose exactly 40
      cfg(4'h1, 2'd0, 0, 0, 0, 2'd0, 5'd0, 8'd255);
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, `OFS_COUNT, 8'h00);
         apb(1'b0, `OFS_COUNT, 8'h00);
         r1 = rd;
         en <= (i == 0);
         repeat (40) @(posedge pclk);
         en <= 1'b1;
         apb(1'b0, `OFS_COUNT, 8'h00);
         if (i == 0)
            p = rd - r1;
         else
            check("frozen by enable", rd - r1 + 40, p);
      end
      emu_halt <= 1'b1;
      cfg(4'h1, 2'd0, 0, 0, 0, 2'd0, 5'd0, 8'd255);
      frozen("halted count");
      cfg(4'h2, 2'd0, 0, 0, 0, 2'd0, 5'd0, 8'd255);
      apb(1'b0, `OFS_COUNT, 8'h00);
      r1 = rd;
      repeat (30) @(posedge pclk);
      apb(1'b0, `OFS_COUNT, 8'h00);
      check("fast osc runs in halt", rd !== r1, 1'b1);
      emu_halt <= 1'b0;
      presetn  <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CONTROL, 8'h00);
      check("control after reset", rd, 32'h0000_0000);
      final_report();
   end
endmodule : testbench
